/* rtl/sscc_core.sv */
// Synchronous serial controller core with AXI4-Lite registers
//
// Overview of operation
// RULE_01: Independent transmitter and receiver share one clock divider.
// RULE_02: Each direction has data, bit clock and frame sync lines.
// RULE_03: Transfers start continuously or on a selected frame sync event.
// RULE_04: Receiver may use transmit clock and/or start with transmitter.
// RULE_05: Transmitter may use receive clock and/or start with receiver.
// RULE_06: External bit clocks must not exceed half the master clock.
// RULE_07: Transmit clock comes from its pad, receive clock or divider.
// RULE_08: Receive clock comes from its pad, transmit clock or divider.
// RULE_09: Each direction can drive its own clock pad out.
// RULE_10: Divider setting is 12 bits, max 4095, ratio up to 8190.
// RULE_11: Setting zero keeps the divider idle with no clock.
// RULE_12: Divided frequency is master clock over twice the setting.
// RULE_13: Each divided clock phase lasts exactly setting master cycles.
// RULE_14: The one divided clock feeds both transmitter and receiver.
// RULE_15: Interrupt asserts while any unmasked source is pending.
// RULE_16: Status register shows which sources are pending.
// RULE_17: Two DMA request channels, one per direction, 32-bit words.
// RULE_18: Transmit-empty when holding and shifter empty; ready on load.
// RULE_19: Unread received word overwritten sets the overrun flag.
// RULE_20: External clocks and frame syncs are synchronised first.
// RULE_21: Writing the divider setting restarts its phase count.
`timescale 1ns/1ps
`default_nettype none
module sscc_core
	import sscc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   tx_serial_out,
	input  wire logic              rx_serial_in,
	input  wire logic              tx_bit_clock_pad_i,
	output logic                   tx_bit_clock_pad_o,
	output logic                   tx_bit_clock_pad_oe,
	input  wire logic              rx_bit_clock_pad_i,
	output logic                   rx_bit_clock_pad_o,
	output logic                   rx_bit_clock_pad_oe,
	input  wire logic              tx_frame_sync_pad,
	input  wire logic              rx_frame_sync_pad,
	output logic                   irq,
	output logic                   dma_tx_req,
	output logic                   dma_rx_req
);
	logic [DIV_W-1:0]  div;
	logic [31:0]       tcmr;
	logic [31:0]       rcmr;
	logic [SR_W-1:0]   imr;
	logic              tx_en;
	logic              rx_en;
	logic [31:0]       thr;
	logic [31:0]       tsr;
	logic [31:0]       rhr;
	logic [31:0]       rsr;
	logic              thr_full;
	logic              tsr_full;
	logic              tx_all_empty_flag;
	logic              tx_holding_free_flag;
	logic              rx_holding_full_flag;
	logic              rx_overrun_flag;
	logic [4:0]        tx_cnt;
	logic [4:0]        rx_cnt;
	sscc_state_t       tx_state;
	sscc_state_t       rx_state;
	logic [1:0]        txc_sync;
	logic [1:0]        rxc_sync;
	logic [1:0]        txfs_sync;
	logic [1:0]        rxfs_sync;
	logic              txfs_q;
	logic              rxfs_q;
	logic              tx_bclk;
	logic              rx_bclk;
	logic              tx_bclk_q;
	logic              rx_bclk_q;
	logic              tx_fall;
	logic              rx_rise;
	logic              div_clk;
	logic              div_wr;
	logic              aw_hold;
	logic              w_hold;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic              wr_go;
	logic              rd_go;
	logic              thr_wr;
	logic              rhr_rd;
	logic              tx_load;
	logic              rx_done;
	logic              tx_start_now;
	logic              rx_start_now;
	logic [SR_W-1:0]   sr_pend;

	// Selects a bit clock from its three candidate sources [RULE_07] [RULE_08]
	function automatic logic pick_clk(input logic [1:0] cks, input logic divc,
		input logic other, input logic pad);
		unique case (cks)
			SSCC_CKS_DIV:   pick_clk = divc; // [RULE_14]
			SSCC_CKS_OTHER: pick_clk = other;
			SSCC_CKS_PAD:   pick_clk = pad;
			default:        pick_clk = 1'b0;
		endcase
	endfunction : pick_clk

	// Evaluates the start condition on a frame sync line [RULE_03]
	function automatic logic start_hit(input logic [2:0] sel, input logic fs,
		input logic fs_q, input logic other_go, input logic cont_ok);
		unique case (sel)
			SSCC_ST_CONT:  start_hit = cont_ok;
			SSCC_ST_OTHER: start_hit = other_go;
			SSCC_ST_LOW:   start_hit = !fs;
			SSCC_ST_HIGH:  start_hit = fs;
			SSCC_ST_FALL:  start_hit = fs_q && !fs;
			SSCC_ST_RISE:  start_hit = !fs_q && fs;
			SSCC_ST_ANY:   start_hit = fs_q != fs;
			default:       start_hit = 1'b0;
		endcase
	endfunction : start_hit

	// Clock divider shared by both directions [RULE_01] [RULE_10]
	sscc_clk_div #(
		.W (DIV_W)
	) u_div (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.div      (div),
		.div_wr   (div_wr),
		.div_clk  (div_clk),
		.div_rise (),
		.div_fall ()
	);

	// Pad synchronisers, first stage read only by second [RULE_20] [RULE_06] [RULE_02]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txc_sync  <= '0;
			rxc_sync  <= '0;
			txfs_sync <= '0;
			rxfs_sync <= '0;
			txfs_q    <= 1'b0;
			rxfs_q    <= 1'b0;
		end else if (ce) begin
			txc_sync  <= {txc_sync[0], tx_bit_clock_pad_i};
			rxc_sync  <= {rxc_sync[0], rx_bit_clock_pad_i};
			txfs_sync <= {txfs_sync[0], tx_frame_sync_pad};
			rxfs_sync <= {rxfs_sync[0], rx_frame_sync_pad};
			txfs_q    <= txfs_sync[1];
			rxfs_q    <= rxfs_sync[1];
		end
	end

	// Cross-selected bit clocks; other-source loops fall back to divider
	assign tx_bclk = pick_clk(tcmr[CM_CKS_LO+:2], div_clk,
		(rcmr[CM_CKS_LO+:2] == SSCC_CKS_PAD) ? rxc_sync[1] : div_clk, txc_sync[1]); // [RULE_05]
	assign rx_bclk = pick_clk(rcmr[CM_CKS_LO+:2], div_clk,
		(tcmr[CM_CKS_LO+:2] == SSCC_CKS_PAD) ? txc_sync[1] : div_clk, rxc_sync[1]); // [RULE_04]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_bclk_q <= 1'b0;
			rx_bclk_q <= 1'b0;
		end else if (ce) begin
			tx_bclk_q <= tx_bclk;
			rx_bclk_q <= rx_bclk;
		end
	end

	assign tx_fall = ce && tx_bclk_q && !tx_bclk;
	assign rx_rise = ce && !rx_bclk_q && rx_bclk;

	// Clock pad drive [RULE_09]
	assign tx_bit_clock_pad_oe = tcmr[CM_CKO];
	assign tx_bit_clock_pad_o  = tcmr[CM_CKO] && tx_bclk;
	assign rx_bit_clock_pad_oe = rcmr[CM_CKO];
	assign rx_bit_clock_pad_o  = rcmr[CM_CKO] && rx_bclk;

	// AXI4-Lite write channel
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign wr_go  = ce && aw_hold && w_hold && !s_axi_bvalid;
	assign div_wr = wr_go && aw_addr == REG_CMR;
	assign thr_wr = wr_go && aw_addr == REG_THR;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr > REG_IMR || aw_addr[1:0] != 2'b00) ?
					RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div   <= '0;
			tcmr  <= '0;
			rcmr  <= '0;
			imr   <= '0;
			tx_en <= 1'b0;
			rx_en <= 1'b0;
		end else if (wr_go) begin
			unique case (aw_addr)
				REG_CTRL: begin
					if (w_data[CTRL_TXDIS])
						tx_en <= 1'b0;
					else if (w_data[CTRL_TXEN])
						tx_en <= 1'b1;
					if (w_data[CTRL_RXDIS])
						rx_en <= 1'b0;
					else if (w_data[CTRL_RXEN])
						rx_en <= 1'b1;
				end
				REG_CMR:  div  <= w_data[DIV_W-1:0];
				REG_TCMR: tcmr <= w_data;
				REG_RCMR: rcmr <= w_data;
				REG_IER:  imr  <= imr | w_data[SR_W-1:0]; // [RULE_15]
				REG_IDR:  imr  <= imr & ~w_data[SR_W-1:0];
				default:  ;
			endcase
		end
	end

	// AXI4-Lite read channel; reading the receive word clears its flags
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go  = ce && s_axi_arvalid && s_axi_arready;
	assign rhr_rd = rd_go && s_axi_araddr == REG_RHR;
	assign sr_pend = {rx_overrun_flag, rx_holding_full_flag, 2'b00,
		tx_all_empty_flag, tx_holding_free_flag};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					REG_CMR:  s_axi_rdata <= 32'(div);
					REG_TCMR: s_axi_rdata <= tcmr;
					REG_RCMR: s_axi_rdata <= rcmr;
					REG_THR:  s_axi_rdata <= thr;
					REG_RHR:  s_axi_rdata <= rhr;
					REG_SR:   s_axi_rdata <= 32'(sr_pend) | (32'(tx_en) << SR_TXEN)
						| (32'(rx_en) << SR_RXEN); // [RULE_16]
					REG_IMR:  s_axi_rdata <= 32'(imr);
					REG_CTRL, REG_IER, REG_IDR: s_axi_rdata <= '0;
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign irq        = |(sr_pend & imr); // [RULE_15]
	assign dma_tx_req = tx_en && tx_holding_free_flag; // [RULE_17]
	assign dma_rx_req = rx_holding_full_flag; // [RULE_17]

	// Start events, cross-triggered [RULE_03] [RULE_04] [RULE_05]
	assign tx_start_now = start_hit(tcmr[CM_START_LO+:3], txfs_sync[1], txfs_q,
		rx_state == SSCC_SHIFT, thr_full || tsr_full);
	// Receiver joins at the first transmitted bit, never sampling a stale one
	assign rx_start_now = start_hit(rcmr[CM_START_LO+:3], rxfs_sync[1], rxfs_q,
		tx_state == SSCC_SHIFT && tx_fall, 1'b1);

	assign tx_load = tx_en && thr_full && !tsr_full;

	// Transmitter: holding word, shifter, flags [RULE_18]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			thr      <= '0;
			tsr      <= '0;
			thr_full <= 1'b0;
			tsr_full <= 1'b0;
			tx_cnt   <= '0;
			tx_state <= SSCC_IDLE;
			tx_serial_out <= 1'b0;
		end else if (ce) begin
			if (thr_wr) begin
				thr      <= w_data;
				thr_full <= 1'b1;
			end else if (tx_load) begin
				thr_full <= 1'b0;
			end
			if (tx_load) begin
				tsr      <= thr;
				tsr_full <= 1'b1;
			end
			unique case (tx_state)
				SSCC_IDLE: if (tx_en && (tsr_full || tx_load))
					tx_state <= SSCC_WAIT;
				SSCC_WAIT: if (!tx_en)
					tx_state <= SSCC_IDLE;
				else if (tx_start_now && tsr_full) begin
					tx_state <= SSCC_SHIFT;
					tx_cnt   <= tcmr[CM_LEN_LO+:5];
				end
				SSCC_SHIFT: if (tx_fall) begin
					tx_serial_out <= tsr[DATA_W-1];
					tsr <= {tsr[DATA_W-2:0], 1'b0};
					if (tx_cnt == '0) begin
						tsr_full <= 1'b0;
						tx_state <= SSCC_IDLE;
					end else begin
						tx_cnt <= tx_cnt - 5'd1;
					end
				end
				default: tx_state <= SSCC_IDLE;
			endcase
		end
	end

	assign tx_holding_free_flag = !thr_full; // [RULE_18]
	assign tx_all_empty_flag    = !thr_full && !tsr_full; // [RULE_18]
	assign rx_done = rx_state == SSCC_SHIFT && rx_rise && rx_cnt == '0;

	// Receiver: shifter, holding word, overrun [RULE_19]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsr      <= '0;
			rhr      <= '0;
			rx_cnt   <= '0;
			rx_state <= SSCC_IDLE;
			rx_holding_full_flag <= 1'b0;
			rx_overrun_flag      <= 1'b0;
		end else if (ce) begin
			if (rx_done) begin
				rhr <= {rsr[DATA_W-2:0], rx_serial_in};
				rx_holding_full_flag <= 1'b1;
			end else if (rhr_rd) begin
				rx_holding_full_flag <= 1'b0;
			end
			if (rx_done && rx_holding_full_flag && !rhr_rd)
				rx_overrun_flag <= 1'b1; // [RULE_19]
			else if (rhr_rd)
				rx_overrun_flag <= 1'b0;
			unique case (rx_state)
				SSCC_IDLE: if (rx_en)
					rx_state <= SSCC_WAIT;
				SSCC_WAIT: if (!rx_en)
					rx_state <= SSCC_IDLE;
				else if (rx_start_now) begin
					rx_state <= SSCC_SHIFT;
					rx_cnt   <= rcmr[CM_LEN_LO+:5];
				end
				SSCC_SHIFT: if (rx_rise) begin
					rsr <= {rsr[DATA_W-2:0], rx_serial_in};
					if (rx_cnt == '0)
						rx_state <= SSCC_IDLE;
					else
						rx_cnt <= rx_cnt - 5'd1;
				end
				default: rx_state <= SSCC_IDLE;
			endcase
		end
	end
endmodule : sscc_core
`default_nettype wire

/* common/sscc_pkg.sv */
// Constants and types shared by the synchronous serial clock core
package sscc_pkg;
	localparam int          DATA_W      = 32;
	localparam int          DIV_W       = 12;
	localparam logic [11:0] DIV_MAX     = 12'hfff;
	localparam int          ADDR_W      = 8;
	// Register byte addresses
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_CMR     = 8'h04;
	localparam logic [7:0]  REG_TCMR    = 8'h08;
	localparam logic [7:0]  REG_RCMR    = 8'h0c;
	localparam logic [7:0]  REG_THR     = 8'h10;
	localparam logic [7:0]  REG_RHR     = 8'h14;
	localparam logic [7:0]  REG_SR      = 8'h18;
	localparam logic [7:0]  REG_IER     = 8'h1c;
	localparam logic [7:0]  REG_IDR     = 8'h20;
	localparam logic [7:0]  REG_IMR     = 8'h24;
	// Control bits
	localparam int          CTRL_RXEN   = 0;
	localparam int          CTRL_RXDIS  = 1;
	localparam int          CTRL_TXEN   = 8;
	localparam int          CTRL_TXDIS  = 9;
	// Clock mode fields (TCMR/RCMR)
	localparam int          CM_CKS_LO   = 0;
	localparam int          CM_CKO      = 2;
	localparam int          CM_START_LO = 8;
	localparam int          CM_LEN_LO   = 16;
	// Status bits
	localparam int          SR_TX_FREE  = 0;
	localparam int          SR_TX_EMPTY = 1;
	localparam int          SR_RX_FULL  = 4;
	localparam int          SR_OVRUN    = 5;
	localparam int          SR_TXEN     = 16;
	localparam int          SR_RXEN     = 17;
	localparam int          SR_W        = 6;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		SSCC_CKS_DIV   = 2'b00,
		SSCC_CKS_OTHER = 2'b01,
		SSCC_CKS_PAD   = 2'b10
	} sscc_cks_t;
	typedef enum logic [2:0] {
		SSCC_ST_CONT  = 3'b000,
		SSCC_ST_OTHER = 3'b001,
		SSCC_ST_LOW   = 3'b010,
		SSCC_ST_HIGH  = 3'b011,
		SSCC_ST_FALL  = 3'b100,
		SSCC_ST_RISE  = 3'b101,
		SSCC_ST_ANY   = 3'b110
	} sscc_start_t;
	typedef enum logic [1:0] {
		SSCC_IDLE  = 2'b00,
		SSCC_WAIT  = 2'b01,
		SSCC_SHIFT = 2'b10
	} sscc_state_t;
endpackage : sscc_pkg

/* rtl/sscc_clk_div.sv */
// Master clock divider with 50% duty divided clock
`timescale 1ns/1ps
`default_nettype none
module sscc_clk_div
	import sscc_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] div,
	input  wire logic         div_wr,
	output logic              div_clk,
	output logic              div_rise,
	output logic              div_fall
);
	logic [W-1:0] cnt;
	logic         last;

	assign last     = (cnt == div - W'(1));
	assign div_rise = ce && (div != '0) && last && !div_wr && !div_clk;
	assign div_fall = ce && (div != '0) && last && !div_wr && div_clk;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt     <= '0;
			div_clk <= 1'b0;
		end else if (ce) begin
			if (div_wr || div == '0) begin // [RULE_11] [RULE_21]
				cnt     <= '0;
				div_clk <= 1'b0;
			end else if (last) begin // [RULE_12] [RULE_13]
				cnt     <= '0;
				div_clk <= !div_clk;
			end else begin
				cnt <= cnt + W'(1);
			end
		end
	end
endmodule : sscc_clk_div
`default_nettype wire

/* test/sscc_core_assertions.sv */
// Port-level checker for the synchronous serial clock core
`timescale 1ns/1ps
`default_nettype none
module sscc_core_assertions
	import sscc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        tx_bit_clock_pad_o,
	input  wire logic        tx_bit_clock_pad_oe,
	input  wire logic        dma_tx_req,
	input  wire logic        dma_rx_req
);
	logic        aw_hs;
	logic        ar_hs;
	logic [12:0] cnt;
	logic [12:0] last;
	logic [1:0]  vld;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_wr_take;
		aw_hs && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		ar_hs;
	endsequence
	// Running and previous divided clock phase length; any write restarts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 13'h0;
			last <= 13'h0;
			vld <= 2'h0;
		end else if (aw_hs || $past(aw_hs) || $past(aw_hs, 2) || !tx_bit_clock_pad_oe) begin
			cnt <= 13'h0;
			vld <= 2'h0;
		end else if ($changed(tx_bit_clock_pad_o)) begin
			cnt <= 13'h1;
			last <= cnt;
			vld <= (vld == 2'h2) ? 2'h2 : vld + 2'h1;
		end else begin
			cnt <= cnt + 13'h1;
		end
	end
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read not answered");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	a_phase_equal: assert property ($changed(tx_bit_clock_pad_o) && vld == 2'h2 |-> cnt == last)
		else $error("divided clock phases differ");
	a_oe_by_write: assert property ($changed(tx_bit_clock_pad_oe) |-> $past(aw_hs) || $past(aw_hs, 2))
		else $error("clock pad enable changed without write");
	a_tx_req_fall: assert property ($fell(dma_tx_req) |-> $past(aw_hs) || $past(aw_hs, 2))
		else $error("tx request fell without write");
	a_rx_req_fall: assert property ($fell(dma_rx_req) |-> $past(ar_hs) || $past(ar_hs, 2))
		else $error("rx request fell without read");
endmodule : sscc_core_assertions
bind sscc_core sscc_core_assertions i_chk (.*);
`default_nettype wire

/* test/sscc_codec_model.sv */
// Serial-side codec: bit clock, frame sync and data source, or echo of sent data
`timescale 1ns/1ps
`default_nettype none
module sscc_codec_model #(
	parameter int HALF = 8
) (
	input  wire logic       clk,
	input  wire logic       loop_en,
	input  wire logic       send,
	input  wire logic [7:0] word,
	input  wire logic       tx_serial_out,
	output logic            rx_serial_in,
	output logic            ext_clk,
	output logic            fs
);
	logic drv = 1'b0;
	logic busy = 1'b0;
	// Outside a frame the line shows the inverse of the last bit
	assign rx_serial_in = loop_en ? tx_serial_out : (busy ? drv : ~drv);
	initial begin
		ext_clk = 1'b0;
		fs = 1'b0;
	end
	// Clock runs only within a frame, MSB first, data changes on falling edge
	always @(posedge clk) begin
		if (send) begin
			busy <= 1'b1;
			fs <= 1'b1;
			for (int i = 7; i >= 0; i--) begin
				drv <= word[i];
				repeat (HALF) @(posedge clk);
				ext_clk <= 1'b1;
				repeat (HALF) @(posedge clk);
				ext_clk <= 1'b0;
			end
			fs <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule : sscc_codec_model
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the synchronous serial clock core
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sscc_pkg::*;
	logic        clk, rst, ce, loop_en, send, ext_clk;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, word, w0, w1;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        tx_serial_out, rx_serial_in, tx_bit_clock_pad_i, tx_bit_clock_pad_o;
	logic        tx_bit_clock_pad_oe, rx_bit_clock_pad_i, rx_bit_clock_pad_o, rx_bit_clock_pad_oe;
	logic        tx_frame_sync_pad, rx_frame_sync_pad, irq, dma_tx_req, dma_rx_req;
	int          error_cnt, n_compared, cyc, hi, lo, d;
	assign tx_bit_clock_pad_i = tx_bit_clock_pad_oe ? tx_bit_clock_pad_o : 1'b0;
	assign rx_bit_clock_pad_i = rx_bit_clock_pad_oe ? rx_bit_clock_pad_o : ext_clk;
	sscc_core i_dut (.*);
	sscc_codec_model #(.HALF(8)) i_codec (.clk(clk), .loop_en(loop_en), .send(send), .word(word),
		.tx_serial_out(tx_serial_out), .rx_serial_in(rx_serial_in), .ext_clk(ext_clk),
		.fs(rx_frame_sync_pad));
	initial clk = 1'b0;
	always #2 clk = ~clk;
	task automatic wrap_up();
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= dat;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw || w);
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic phases();
		hi = 0;
		lo = 0;
		while (tx_bit_clock_pad_o !== 1'b0) @(posedge clk);
		while (tx_bit_clock_pad_o !== 1'b1) @(posedge clk);
		while (tx_bit_clock_pad_o === 1'b1) begin
			hi++;
			@(posedge clk);
		end
		while (tx_bit_clock_pad_o === 1'b0) begin
			lo++;
			@(posedge clk);
		end
	endtask : phases
	task automatic frame(input logic [7:0] v);
		word <= v;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (140) @(posedge clk);
	endtask : frame
	initial begin
		{rst, ce, s_axi_wstrb} = 6'h3f;
		{loop_en, send, word, tx_frame_sync_pad} = 11'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		void'($urandom(96492));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		axi_rd(REG_IMR);
		chk("imr_reset", rd, 32'h0);
		axi_rd(8'h40);
		chk("unmapped_resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		axi_wr(8'h40, 32'h0);
		chk("unmapped_wr", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		axi_wr(REG_CMR, 32'hffff_ffff);
		chk("wr_okay", {30'h0, rsp}, {30'h0, RESP_OKAY});
		axi_rd(REG_CMR);
		chk("div_width", rd, 32'h0000_0fff);
		axi_wr(REG_TCMR, 32'h4);
		axi_wr(REG_RCMR, 32'h4);
		for (int i = 0; i < 5; i++) begin
			d = (i < 3) ? i + 1 : 4 + $urandom % 13;
			axi_wr(REG_CMR, 32'(d));
			phases();
			chk("div_high", hi, d);
			chk("div_low", lo, d);
			chk("rx_pad_clock", rx_bit_clock_pad_o, tx_bit_clock_pad_o);
			chk("rx_pad_oe", rx_bit_clock_pad_oe, 1);
		end
		axi_wr(REG_CMR, 32'h0);
		hi = 0;
		repeat (40) begin
			@(posedge clk);
			if (tx_bit_clock_pad_o !== 1'b0) hi++;
		end
		chk("div_idle", hi, 0);
		axi_wr(REG_CMR, 32'h4);
		axi_wr(REG_TCMR, 32'h0007_0000);
		axi_wr(REG_RCMR, 32'h0007_0101);
		loop_en <= 1'b1;
		axi_wr(REG_CTRL, 32'h0000_0101);
		chk("dma_tx_req", dma_tx_req, 1);
		axi_wr(REG_IER, 32'h1);
		chk("irq_on", irq, 1);
		axi_wr(REG_IDR, 32'h1);
		chk("irq_off", irq, 0);
		w0 = 8'($urandom);
		axi_wr(REG_THR, {w0, 24'h0});
		do axi_rd(REG_SR); while (rd[SR_RX_FULL] !== 1'b1 || rd[SR_TX_EMPTY] !== 1'b1);
		chk("tx_free", rd[SR_TX_FREE], 1);
		axi_rd(REG_RHR);
		chk("loop_word", rd[7:0], w0);
		chk("dma_rx_idle", dma_rx_req, 0);
		axi_wr(REG_CTRL, 32'h2);
		tx_frame_sync_pad <= 1'b1;
		axi_wr(REG_TCMR, 32'h0007_0200);
		axi_wr(REG_THR, {w0, 24'h0});
		repeat (100) @(posedge clk);
		axi_rd(REG_SR);
		chk("tx_held", rd[SR_TX_EMPTY], 0);
		tx_frame_sync_pad <= 1'b0;
		do axi_rd(REG_SR); while (rd[SR_TX_EMPTY] !== 1'b1);
		axi_wr(REG_RCMR, 32'h0007_0502);
		axi_wr(REG_CTRL, 32'h1);
		loop_en <= 1'b0;
		w0 = 8'($urandom);
		w1 = 8'($urandom);
		frame(w0);
		frame(w1);
		axi_rd(REG_SR);
		chk("overrun", rd[SR_OVRUN], 1);
		chk("rx_full", rd[SR_RX_FULL], 1);
		axi_rd(REG_RHR);
		chk("rx_word", rd[7:0], w1);
		axi_rd(REG_SR);
		chk("overrun_clear", rd[SR_OVRUN], 0);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
